// File: isbie_expander.sv
// Purpose: Two-wire slave with eight byte registers driving sixteen pins
// Assumes: Bus clock well below clk/8; all pins sampled by two flops
// Notes: Pin drivers, bus slave and register file share one state struct
// Notes on behaviour
// - Input direction turns both pin drivers off
// - Output direction drives pin from latch bit
// - SDA falling with SCL high starts transfer
// - Matching address acknowledged low on ninth pulse
// - SDA change during SCL high is control
// - SDA rising with SCL high ends transfer
// - Eight data bits then one acknowledge bit
// - Transmitter releases SDA, receiver pulls low
// - Device acks written bytes, master acks reads
// - Master nack on last read; device releases SDA
// - Address 0x20 or 0x21 from select input
// - Direction flag one reads, zero writes
// - First written byte is command, low three bits
// - Command persists across transactions
// - Commands 0..7 select the eight registers
// - Reset: latches ones, polarity zeros, direction ones
// - Input registers show pins, ignore writes
// - Latch reads return latch, not pin
// - Direction one is input, zero is output
// - Polarity one inverts reported input level
// - Writes alternate between registers of a pair
// - Reads alternate between registers of a pair
`timescale 1ns/1ps
`include "isbie_params.svh"

module isbie_expander (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSel,
  input wire isbie_pkg::isbie_pins_t gpioIn,
  output isbie_pkg::isbie_pins_t gpioOut,
  output isbie_pkg::isbie_pins_t gpioOe,
  output isbie_pkg::isbie_pins_t highSideDriver,
  output isbie_pkg::isbie_pins_t lowSideDriver
);
  import isbie_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0] sclSync;
    logic [2:0] sdaSync;
    logic [1:0] addrSync;
    isbie_pins_t gpioMeta;
    isbie_pins_t gpioSync;
    isbie_state_t state;
    isbie_phase_t phase;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic rwRead;
    logic addrLatch;
    logic masterAck;
    logic pullLow;
    logic [2:0] cmd;
    isbie_regs_t regs;
    isbie_pins_t highDrv;
    isbie_pins_t lowDrv;
  } isbie_core_t;

  isbie_core_t core_reg;
  isbie_core_t core_next;

  logic sclS;
  logic sclPrev;
  logic sdaS;
  logic sdaPrev;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic [7:0] sendByte;

  // Second stage feeds logic; first stage is read only by second
  assign sclS = core_reg.sclSync[1];
  assign sclPrev = core_reg.sclSync[2];
  assign sdaS = core_reg.sdaSync[1];
  assign sdaPrev = core_reg.sdaSync[2];
  assign sclRise = sclS && !sclPrev;
  assign sclFall = !sclS && sclPrev;
  assign startCond = sclS && sclPrev && sdaPrev && !sdaS;
  assign stopCond = sclS && sclPrev && !sdaPrev && sdaS;

  // ****************************************
  // Register access
  // ****************************************
  function automatic logic [7:0] readByte(input isbie_regs_t r,
                                          input logic [2:0] c,
                                          input isbie_pins_t pins);
    logic [7:0] v;
    v = 8'h00;
    case (c)
      `ISBIE_REG_IN_LO: v = pins.lowHalf ^ r.invert.lowHalf;
      `ISBIE_REG_IN_HI: v = pins.highHalf ^ r.invert.highHalf;
      `ISBIE_REG_OUT_LO: v = r.latch.lowHalf;
      `ISBIE_REG_OUT_HI: v = r.latch.highHalf;
      `ISBIE_REG_INV_LO: v = r.invert.lowHalf;
      `ISBIE_REG_INV_HI: v = r.invert.highHalf;
      `ISBIE_REG_DIR_LO: v = r.dir.lowHalf;
      `ISBIE_REG_DIR_HI: v = r.dir.highHalf;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic isbie_regs_t writeByte(input isbie_regs_t r,
                                            input logic [2:0] c,
                                            input logic [7:0] d);
    isbie_regs_t w;
    w = r;
    case (c)
      `ISBIE_REG_OUT_LO: w.latch.lowHalf = d;
      `ISBIE_REG_OUT_HI: w.latch.highHalf = d;
      `ISBIE_REG_INV_LO: w.invert.lowHalf = d;
      `ISBIE_REG_INV_HI: w.invert.highHalf = d;
      `ISBIE_REG_DIR_LO: w.dir.lowHalf = d;
      `ISBIE_REG_DIR_HI: w.dir.highHalf = d;
      default: w = r; // Input registers drop writes
    endcase
    return w;
  endfunction

  // Other register of the same pair
  function automatic logic [2:0] pairNext(input logic [2:0] c);
    return {c[2:1], ~c[0]};
  endfunction

  assign sendByte = readByte(core_reg.regs, core_reg.cmd, core_reg.gpioSync);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    core_next = core_reg;
    core_next.sclSync = {core_reg.sclSync[1:0], sclIn};
    core_next.sdaSync = {core_reg.sdaSync[1:0], sdaIn};
    core_next.addrSync = {core_reg.addrSync[0], addrSel};
    core_next.gpioMeta = gpioIn;
    core_next.gpioSync = core_reg.gpioMeta;
    case (core_reg.state)
      ST_RECV: begin
        if (sclRise) begin
          core_next.shift = {core_reg.shift[6:0], sdaS};
          core_next.bitCnt = core_reg.bitCnt + 4'h1;
        end else if (sclFall && core_reg.bitCnt == `ISBIE_BYTE_BITS) begin
          // Byte complete: act on it and acknowledge; a foreign address is ignored
          core_next.state = ST_ACK;
          core_next.pullLow = 1'b1;
          case (core_reg.phase)
            PH_ADDR: begin
              if (core_reg.shift[7:1] ==
                  {`ISBIE_ADDR_UPPER, core_reg.addrLatch}) begin
                core_next.rwRead = core_reg.shift[0];
              end else begin
                core_next.state = ST_IGNORE;
                core_next.pullLow = 1'b0;
              end
            end
            PH_CMD: begin
              core_next.cmd = core_reg.shift[2:0];
            end
            default: begin
              core_next.regs = writeByte(core_reg.regs, core_reg.cmd,
                                         core_reg.shift);
              core_next.cmd = pairNext(core_reg.cmd);
            end
          endcase
        end
      end
      ST_ACK: begin
        if (sclFall) begin
          if (core_reg.phase == PH_ADDR && core_reg.rwRead) begin
            core_next.state = ST_SEND;
            core_next.shift = sendByte;
            core_next.pullLow = ~sendByte[7];
            core_next.bitCnt = 4'h1;
          end else begin
            core_next.state = ST_RECV;
            core_next.pullLow = 1'b0;
            core_next.bitCnt = 4'h0;
            core_next.phase =
              (core_reg.phase == PH_ADDR) ? PH_CMD : PH_DATA;
          end
        end
      end
      ST_SEND: begin
        if (sclFall) begin
          if (core_reg.bitCnt < `ISBIE_BYTE_BITS) begin
            core_next.pullLow = ~core_reg.shift[6];
            core_next.shift = {core_reg.shift[6:0], 1'b0};
            core_next.bitCnt = core_reg.bitCnt + 4'h1;
          end else begin
            core_next.state = ST_MACK;
            core_next.pullLow = 1'b0;
            core_next.cmd = pairNext(core_reg.cmd);
          end
        end
      end
      ST_MACK: begin
        if (sclRise) begin
          core_next.masterAck = ~sdaS;
        end else if (sclFall) begin
          if (core_reg.masterAck) begin
            core_next.state = ST_SEND;
            core_next.shift = sendByte;
            core_next.pullLow = ~sendByte[7];
            core_next.bitCnt = 4'h1;
          end else begin
            core_next.state = ST_IGNORE;
          end
        end
      end
      ST_IDLE: core_next.pullLow = 1'b0;
      ST_IGNORE: core_next.pullLow = 1'b0;
      default: core_next.state = ST_IDLE;
    endcase
    // Start or repeated start overrides any byte in flight
    // Command left alone so later reads keep their register
    if (startCond) begin
      core_next.state = ST_RECV;
      core_next.phase = PH_ADDR;
      core_next.bitCnt = 4'h0;
      core_next.pullLow = 1'b0;
      core_next.rwRead = 1'b0;
      core_next.addrLatch = core_reg.addrSync[1];
    end else if (stopCond) begin
      core_next.state = ST_IDLE;
      core_next.pullLow = 1'b0;
    end
    // Drivers registered on the same edge as the registers
    core_next.highDrv = ~core_next.regs.dir & core_next.regs.latch;
    core_next.lowDrv = ~core_next.regs.dir & ~core_next.regs.latch;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_reg <= '0;
      core_reg.sclSync <= 3'h7;
      core_reg.sdaSync <= 3'h7;
      core_reg.regs.latch <= {`ISBIE_RST_LATCH, `ISBIE_RST_LATCH};
      core_reg.regs.invert <= {`ISBIE_RST_INVERT, `ISBIE_RST_INVERT};
      core_reg.regs.dir <= {`ISBIE_RST_DIR, `ISBIE_RST_DIR};
    end else begin
      core_reg <= core_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Open drain: only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe = core_reg.pullLow;
  assign highSideDriver = core_reg.highDrv;
  assign lowSideDriver = core_reg.lowDrv;
  assign gpioOut = core_reg.highDrv;
  assign gpioOe = core_reg.highDrv | core_reg.lowDrv;

  // ****************************************
  // Checks
  // ****************************************
  sequence startSeq;
    startCond;
  endsequence

  sequence stopSeq;
    stopCond;
  endsequence

  sequence addrByteDone;
    core_reg.state == ST_RECV && core_reg.phase == PH_ADDR &&
      core_reg.bitCnt == `ISBIE_BYTE_BITS ##0 sclFall;
  endsequence

  inputs_hiz_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ((core_reg.highDrv | core_reg.lowDrv) & core_reg.regs.dir) == 16'h0000)
    else $error("driver on for an input pin");

  drive_pick_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $changed(core_reg.regs) |=>
      highSideDriver == (~$past(core_reg.regs.dir) &
                         $past(core_reg.regs.latch)) &&
      lowSideDriver == (~$past(core_reg.regs.dir) &
                        ~$past(core_reg.regs.latch)))
    else $error("pin drivers do not follow latch and direction");

  start_seen_a: assert property (
    @(posedge clk) disable iff (!nrst)
    startSeq |=> core_reg.state == ST_RECV &&
      core_reg.phase == PH_ADDR && core_reg.bitCnt == 4'h0 && !sdaOe)
    else $error("start not taken");

  addr_ack_a: assert property (
    @(posedge clk) disable iff (!nrst)
    addrByteDone ##0 (core_reg.shift[7:1] ==
      {`ISBIE_ADDR_UPPER, core_reg.addrLatch}) && !startCond && !stopCond
      |=> sdaOe && core_reg.state == ST_ACK)
    else $error("own address not acknowledged");

  addr_miss_a: assert property (
    @(posedge clk) disable iff (!nrst)
    addrByteDone ##0 (core_reg.shift[7:1] !=
      {`ISBIE_ADDR_UPPER, core_reg.addrLatch}) && !startCond && !stopCond
      |=> !sdaOe && core_reg.state == ST_IGNORE)
    else $error("foreign address not ignored");

  ignore_quiet_a: assert property (
    @(posedge clk) disable iff (!nrst)
    core_reg.state == ST_IGNORE && !startCond |=> !sdaOe &&
      $stable(core_reg.regs))
    else $error("active while ignoring");

  stop_seen_a: assert property (
    @(posedge clk) disable iff (!nrst)
    stopSeq ##0 !startCond |=> core_reg.state == ST_IDLE && !sdaOe)
    else $error("stop not taken");

  nack_release_a: assert property (
    @(posedge clk) disable iff (!nrst)
    core_reg.state == ST_MACK && !core_reg.masterAck && sclFall &&
      !startCond && !stopCond |=> !sdaOe ##1 !sdaOe)
    else $error("SDA held after master nack");

  cmd_steady_a: assert property (
    @(posedge clk) disable iff (!nrst)
    core_reg.state inside {ST_IDLE, ST_IGNORE} |=> $stable(core_reg.cmd))
    else $error("command changed outside a byte");

  pair_write_a: assert property (
    @(posedge clk) disable iff (!nrst)
    core_reg.state == ST_RECV && core_reg.phase == PH_DATA &&
      core_reg.bitCnt == `ISBIE_BYTE_BITS && sclFall && !startCond &&
      !stopCond |=> core_reg.cmd == {$past(core_reg.cmd[2:1]),
                                     ~$past(core_reg.cmd[0])})
    else $error("write did not move to pair partner");

  rw_flag_a: assert property (
    @(posedge clk) disable iff (!nrst)
    core_reg.state == ST_ACK && core_reg.phase == PH_ADDR &&
      core_reg.rwRead && sclFall && !startCond && !stopCond
      |=> core_reg.state == ST_SEND)
    else $error("read flag did not start sending");

endmodule

// File: isbie_params.svh
// Purpose: Constants for the sixteen-bit expander: address, offsets, resets
// Assumes: Included by the expander module only
// Notes: Register offsets double as command byte values
`ifndef ISBIE_PARAMS_SVH
`define ISBIE_PARAMS_SVH

// Upper six bits of the 7-bit bus address; select input is bit 0
`define ISBIE_ADDR_UPPER 6'h10

`define ISBIE_BYTE_BITS 4'h8

`define ISBIE_REG_IN_LO 3'h0
`define ISBIE_REG_IN_HI 3'h1
`define ISBIE_REG_OUT_LO 3'h2
`define ISBIE_REG_OUT_HI 3'h3
`define ISBIE_REG_INV_LO 3'h4
`define ISBIE_REG_INV_HI 3'h5
`define ISBIE_REG_DIR_LO 3'h6
`define ISBIE_REG_DIR_HI 3'h7

`define ISBIE_RST_LATCH 8'hff
`define ISBIE_RST_INVERT 8'h00
`define ISBIE_RST_DIR 8'hff

`endif

// File: isbie_pkg.sv
// Purpose: Types shared by the sixteen-bit expander
// Assumes: Nothing beyond the standard language
// Notes: Pin groups travel as one struct of two halves
package isbie_pkg;

  typedef struct packed {
    logic [7:0] highHalf;
    logic [7:0] lowHalf;
  } isbie_pins_t;

  typedef struct packed {
    isbie_pins_t latch;
    isbie_pins_t invert;
    isbie_pins_t dir;
  } isbie_regs_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_ACK,
    ST_SEND,
    ST_MACK,
    ST_IGNORE
  } isbie_state_t;

  typedef enum logic [1:0] {
    PH_ADDR,
    PH_CMD,
    PH_DATA
  } isbie_phase_t;

endpackage

// File: isbie_bus_master.sv
// Purpose: Behavioural two-wire bus master facing the expander
// Assumes: Bus wire has a pull-up; SCL rests high between frames
// Notes: Timing in clk ticks; q is a quarter bus period, raise it to slow
`timescale 1ns/1ps

module isbie_bus_master (
  input wire logic clk,
  input wire logic sdaWire,
  output logic sclOut,
  output logic sdaLow
);
  int q = 10;

  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Also serves as a repeated start
  task automatic start();
    sdaLow <= 1'b0;
    tick(q);
    sclOut <= 1'b1;
    tick(q);
    sdaLow <= 1'b1;
    tick(q);
    sclOut <= 1'b0;
    tick(q);
  endtask

  // Data moves only while SCL is low
  task automatic putBit(input logic b);
    sdaLow <= ~b;
    tick(q);
    sclOut <= 1'b1;
    tick(2 * q);
    sclOut <= 1'b0;
    tick(q);
  endtask

  task automatic getBit(output logic b);
    sdaLow <= 1'b0;
    tick(q);
    sclOut <= 1'b1;
    tick(q);
    b = sdaWire;
    tick(q);
    sclOut <= 1'b0;
    tick(q);
  endtask

  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) putBit(d[i]);
    getBit(b);
    ack = ~b;
  endtask

  task automatic recvByte(input logic last, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      getBit(b);
      d[i] = b;
    end
    putBit(last);
  endtask

  task automatic stop();
    sdaLow <= 1'b1;
    tick(q);
    sclOut <= 1'b1;
    tick(q);
    sdaLow <= 1'b0;
    tick(2 * q);
  endtask
endmodule

// File: tb.sv
// Purpose: Self-checking bench for the sixteen-bit expander
// Assumes: Pins resolve from device drivers over an external pattern
// Notes: Row table covers register traffic; odd cases follow it
`timescale 1ns/1ps

module tb;
  import isbie_pkg::*;

  typedef struct packed {
    logic [2:0] cmd;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] e0;
    logic [7:0] e1;
  } isbie_row_t;

  localparam logic [6:0] BASE = 7'h20;
  logic clk = 1'b0;
  logic nrst;
  logic addrSel;
  logic sdaOut;
  logic sdaOe;
  logic sclOut;
  logic sdaLow;
  logic sdaWire;
  logic [15:0] extPins;
  isbie_pins_t gpioIn;
  isbie_pins_t gpioOut;
  isbie_pins_t gpioOe;
  isbie_pins_t highSide;
  isbie_pins_t lowSide;
  int badCount = 0;
  int checked = 0;
  isbie_row_t rows[6] = '{
    '{3'h0, 8'h11, 8'h22, 8'hc3, 8'h5a},
    '{3'h5, 8'h0f, 8'hf0, 8'h0f, 8'hf0},
    '{3'h1, 8'h00, 8'h00, 8'h55, 8'h33},
    '{3'h2, 8'h96, 8'h3c, 8'h96, 8'h3c},
    '{3'h6, 8'h0f, 8'h00, 8'h0f, 8'h00},
    '{3'h0, 8'haa, 8'h55, 8'h63, 8'h33}
  };

  always #2 clk = ~clk;

  // Pull-up bus wire; device only ever pulls low
  assign sdaWire = ~sdaLow & ~(sdaOe & ~sdaOut);

  always @(posedge clk) gpioIn <= (gpioOut & gpioOe) | (extPins & ~gpioOe);

  isbie_bus_master m (
    .clk(clk),
    .sdaWire(sdaWire),
    .sclOut(sclOut),
    .sdaLow(sdaLow)
  );

  isbie_expander uut (
    .clk(clk),
    .nrst(nrst),
    .sclIn(sclOut),
    .sdaIn(sdaWire),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .addrSel(addrSel),
    .gpioIn(gpioIn),
    .gpioOut(gpioOut),
    .gpioOe(gpioOe),
    .highSideDriver(highSide),
    .lowSideDriver(lowSide)
  );

  task automatic summarize();
    if (badCount == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkAck(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] c, input int n, input logic [7:0] d0,
                    input logic [7:0] d1);
    logic a;
    m.start();
    m.sendByte({BASE[6:1], addrSel, 1'b0}, a);
    chkAck(a, 1'b1);
    m.sendByte({5'h00, c}, a);
    chkAck(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.sendByte(i[0] ? d1 : d0, a);
      chkAck(a, 1'b1);
    end
    m.stop();
  endtask

  task automatic rd(input int n, input logic [7:0] e0, input logic [7:0] e1);
    logic a;
    logic [7:0] d;
    m.start();
    m.sendByte({BASE[6:1], addrSel, 1'b1}, a);
    chkAck(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.recvByte(i == n - 1, d);
      chk({8'h00, d}, {8'h00, i[0] ? e1 : e0});
    end
    chkAck(sdaOe, 1'b0);
    chkAck(sdaOut, 1'b0);
    m.stop();
  endtask

  initial begin
    logic a;
    logic [7:0] d;
    nrst = 1'b0;
    addrSel = 1'b0;
    extPins = 16'h5ac3;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    m.tick(4);
    chk(gpioOe | highSide | lowSide, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].cmd, 2, rows[i].d0, rows[i].d1);
      rd(2, rows[i].e0, rows[i].e1);
    end
    chk(gpioOe, 16'hfff0);
    chk(highSide, 16'h3c90);
    chk(gpioOut, 16'h3c90);
    chk(lowSide, 16'hc360);
    // Select changes only between frames
    @(posedge clk) addrSel <= 1'b1;
    m.start();
    m.sendByte({BASE, 1'b0}, a);
    chkAck(a, 1'b0);
    m.sendByte(8'h06, a);
    chkAck(a, 1'b0);
    m.sendByte(8'hff, a);
    chkAck(a, 1'b0);
    m.stop();
    chk(gpioOe, 16'hfff0);
    wr(3'h2, 0, 8'h00, 8'h00);
    rd(3, 8'h96, 8'h3c);
    // Command write, repeated start, then read in one frame
    m.start();
    m.sendByte({BASE[6:1], addrSel, 1'b0}, a);
    chkAck(a, 1'b1);
    m.sendByte(8'h03, a);
    chkAck(a, 1'b1);
    m.start();
    m.sendByte({BASE[6:1], addrSel, 1'b1}, a);
    chkAck(a, 1'b1);
    m.recvByte(1'b0, d);
    chk({8'h00, d}, 16'h003c);
    m.recvByte(1'b1, d);
    chk({8'h00, d}, 16'h0096);
    m.stop();
    @(posedge clk) nrst <= 1'b0;
    m.tick(5);
    chk(gpioOe | gpioOut | highSide | lowSide, 16'h0000);
    nrst <= 1'b1;
    m.tick(4);
    for (int k = 0; k < 3; k++) begin
      wr(3'(2 + 2 * k), 0, 8'h00, 8'h00);
      rd(2, k == 1 ? 8'h00 : 8'hff, k == 1 ? 8'h00 : 8'hff);
    end
    summarize();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    badCount++;
    summarize();
  end
endmodule
